// File: src/dpsf_host.sv
`include "dpsf_map.svh"
module dpsf_host
  import dpsf_pkg::*;
#(
  parameter logic [7:0] WR_CYC = 8'(`DPSF_WR_CYC),
  parameter logic [7:0] GAP_CYC = 8'(`DPSF_GAP_CYC),
  parameter logic [7:0] RD_CYC = 8'(`DPSF_RD_CYC)
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire dpsf_cmd_t cmd,
  output logic cmd_ready,
  input wire logic cmd_abort,
  output logic rsp_valid,
  output dpsf_rsp_t rsp,
  output logic token_space_select_n,
  output logic mem_select_n,
  output logic rw_n,
  output logic oe_n,
  output logic [`DPSF_ADDR_W-1:0] addr,
  output logic [`DPSF_DATA_W-1:0] data_o,
  output logic data_oe,
  input wire logic [`DPSF_DATA_W-1:0] data_i
);
  // ========================================================
  // Control state
  dpsf_state_t state_q;
  dpsf_op_t op_q;
  logic [2:0] idx_q;
  logic [7:0] cnt_q;
  logic wpend_q;
  logic cmd_ready_q;
  logic rsp_valid_q;
  dpsf_rsp_t rsp_q;
  logic [`DPSF_DATA_W-1:0] s1_q, s2_q, s3_q, dst_q;
  logic last;

  assign last = (cnt_q == 8'h00);

  // Data pins: three stages, a bit changes once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      dst_q <= '1;
    end else begin
      s1_q <= data_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < `DPSF_DATA_W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          dst_q[i] <= s3_q[i];
        end
      end
    end
  end

  // Sequencer; starts by freeing every flag
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= DPSF_S_GAP;
      op_q <= DPSF_OP_INIT;
      idx_q <= 3'h0;
      cnt_q <= 8'h00;
      wpend_q <= 1'b1;
      cmd_ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      rsp_valid_q <= 1'b0;
      case (state_q)
        DPSF_S_IDLE: begin
          if (cmd_valid && cmd_ready_q) begin
            cmd_ready_q <= 1'b0;
            idx_q <= cmd.idx;
            op_q <= (cmd.op == DPSF_OP_ACQ) ? DPSF_OP_ACQ :
                    (cmd.op == DPSF_OP_REL) ? DPSF_OP_REL : DPSF_OP_INIT;
            if (cmd.op == DPSF_OP_INIT) begin
              idx_q <= 3'h0;
            end
            wpend_q <= 1'b1;
            cnt_q <= GAP_CYC - 8'h01;
            state_q <= DPSF_S_GAP;
          end
        end
        DPSF_S_GAP: begin
          cnt_q <= cnt_q - 8'h01;
          if (last) begin
            if (wpend_q) begin
              wpend_q <= 1'b0;
              cnt_q <= WR_CYC - 8'h01;
              state_q <= DPSF_S_WR;
            end else if (op_q == DPSF_OP_INIT && idx_q != `DPSF_LAST_IDX) begin
              idx_q <= idx_q + 3'h1;
              cnt_q <= WR_CYC - 8'h01;
              state_q <= DPSF_S_WR;
            end else if (op_q == DPSF_OP_ACQ || op_q == DPSF_OP_POLL) begin
              cnt_q <= RD_CYC - 8'h01;
              state_q <= DPSF_S_RD;
            end else begin
              rsp_valid_q <= 1'b1;
              rsp_q <= '{granted: 1'b0, idx: idx_q};
              cmd_ready_q <= 1'b1;
              state_q <= DPSF_S_IDLE;
            end
          end
        end
        DPSF_S_WR: begin
          cnt_q <= cnt_q - 8'h01;
          if (last) begin
            cnt_q <= GAP_CYC - 8'h01;
            state_q <= DPSF_S_GAP;
          end
        end
        default: begin
          cnt_q <= cnt_q - 8'h01;
          if (last) begin
            if (!dst_q[0]) begin
              rsp_valid_q <= 1'b1;
              rsp_q <= '{granted: 1'b1, idx: idx_q};
              cmd_ready_q <= 1'b1;
              state_q <= DPSF_S_IDLE;
            end else begin
              // Failed: poll again, or withdraw with a one
              op_q <= cmd_abort ? DPSF_OP_REL : DPSF_OP_POLL;
              wpend_q <= cmd_abort;
              cnt_q <= GAP_CYC - 8'h01;
              state_q <= DPSF_S_GAP;
            end
          end
        end
      endcase
    end
  end

  // Pins follow the state one cycle later
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      token_space_select_n <= 1'b1;
      mem_select_n <= 1'b1;
      rw_n <= 1'b1;
      oe_n <= 1'b1;
      addr <= '0;
      data_o <= '0;
      data_oe <= 1'b0;
    end else begin
      mem_select_n <= 1'b1;
      token_space_select_n <= !(state_q == DPSF_S_WR ||
                                state_q == DPSF_S_RD);
      rw_n <= (state_q != DPSF_S_WR);
      oe_n <= (state_q != DPSF_S_RD);
      data_oe <= (state_q == DPSF_S_WR);
      addr <= {{(`DPSF_ADDR_W-3){1'b0}}, idx_q};
      data_o <= (op_q == DPSF_OP_ACQ) ? '0 : '1;
    end
  end

  assign cmd_ready = cmd_ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp = rsp_q;

  // ========================================================
  // Checks
  logic wrote_q;
  logic seen_rdy_q;
  logic [3:0] wr1_cnt_q;
  logic fail_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wrote_q <= 1'b0;
      seen_rdy_q <= 1'b0;
      wr1_cnt_q <= 4'h0;
      fail_q <= 1'b0;
    end else begin
      if (!rw_n && !token_space_select_n) begin
        wrote_q <= 1'b1;
      end else if (state_q == DPSF_S_IDLE) begin
        wrote_q <= 1'b0;
      end
      if ($rose(rw_n) && data_o[0] && !seen_rdy_q) begin
        wr1_cnt_q <= wr1_cnt_q + 4'h1;
      end
      if (cmd_ready_q) begin
        seen_rdy_q <= 1'b1;
      end
      fail_q <= (state_q == DPSF_S_RD) && last && dst_q[0];
    end
  end

  property p_mem_high;
    @(posedge core_clk) disable iff (!rst_n) mem_select_n;
  endproperty
  a_mem_high: assert property (p_mem_high)
    else $error("memory select driven low");

  property p_tok_ctrl;
    @(posedge core_clk) disable iff (!rst_n)
      !token_space_select_n |-> (rw_n != oe_n) && (data_oe == !rw_n);
  endproperty
  a_tok_ctrl: assert property (p_tok_ctrl)
    else $error("bad control mix in token space access");

  property p_wr_val;
    @(posedge core_clk) disable iff (!rst_n)
      data_oe |-> (data_o[0] == (op_q != DPSF_OP_ACQ));
  endproperty
  a_wr_val: assert property (p_wr_val)
    else $error("write value does not match request or release");

  property p_wr_first;
    @(posedge core_clk) disable iff (!rst_n) $fell(oe_n) |-> wrote_q;
  endproperty
  a_wr_first: assert property (p_wr_first)
    else $error("flag read before any write");

  property p_poll_gap;
    @(posedge core_clk) disable iff (!rst_n)
      $fell(oe_n) |-> $past(token_space_select_n, 1);
  endproperty
  a_poll_gap: assert property (p_poll_gap)
    else $error("read started without select gap");

  property p_fail_follow;
    @(posedge core_clk) disable iff (!rst_n)
      fail_q |-> ##[1:300] (!token_space_select_n && (!oe_n || data_o[0]));
  endproperty
  a_fail_follow: assert property (p_fail_follow)
    else $error("failed request left hanging");

  property p_init;
    @(posedge core_clk) disable iff (!rst_n)
      ($rose(cmd_ready_q) && !seen_rdy_q) |-> (wr1_cnt_q == 4'h8);
  endproperty
  a_init: assert property (p_init)
    else $error("ready before all flags freed");

  c_grant: cover property (@(posedge core_clk) disable iff (!rst_n)
    rsp_valid_q && rsp_q.granted);
  c_fail: cover property (@(posedge core_clk) disable iff (!rst_n)
    fail_q);
  c_withdraw: cover property (@(posedge core_clk) disable iff (!rst_n)
    rsp_valid_q && !rsp_q.granted && op_q == DPSF_OP_REL);
endmodule

// File: src/dpsf_map.svh
`ifndef DPSF_MAP_SVH
`define DPSF_MAP_SVH
// ==========================================================
// Timing of the semaphore port, core_clk at 125 MHz
`define DPSF_CLK_NS 8
`define DPSF_CYC(ns) (((ns) + `DPSF_CLK_NS - 1) / `DPSF_CLK_NS)
// Least write strobe width
`define DPSF_T_WR_NS 45
// Least time with both selects inactive between accesses
`define DPSF_T_GAP_NS 20
// Least read access time, sync latency added on top
`define DPSF_T_RD_NS 55
`define DPSF_SYNC_CYC 3
`define DPSF_WR_CYC `DPSF_CYC(`DPSF_T_WR_NS)
`define DPSF_GAP_CYC `DPSF_CYC(`DPSF_T_GAP_NS)
`define DPSF_RD_CYC (`DPSF_CYC(`DPSF_T_RD_NS) + `DPSF_SYNC_CYC)
// ==========================================================
// Flag space
`define DPSF_NUM_FLAGS 8
`define DPSF_LAST_IDX 3'h7
`define DPSF_DATA_W 8
`define DPSF_ADDR_W 16
`endif

// File: src/dpsf_pkg.sv
package dpsf_pkg;
  // ========================================================
  // Command, answer and state types
  typedef enum logic [1:0] {
    DPSF_OP_INIT = 2'h0,
    DPSF_OP_ACQ = 2'h1,
    DPSF_OP_REL = 2'h2,
    DPSF_OP_POLL = 2'h3
  } dpsf_op_t;

  typedef struct packed {
    dpsf_op_t op;
    logic [2:0] idx;
  } dpsf_cmd_t;

  typedef struct packed {
    logic granted;
    logic [2:0] idx;
  } dpsf_rsp_t;

  typedef enum logic [3:0] {
    DPSF_S_IDLE = 4'h1,
    DPSF_S_GAP = 4'h2,
    DPSF_S_WR = 4'h4,
    DPSF_S_RD = 4'h8
  } dpsf_state_t;
endpackage

// File: dv/dpsf_dev_model.sv
// ========================================================
// Behavioural flag device, left port on host, right on bench
module dpsf_dev_model (
  input wire logic core_clk,
  input wire logic tss_n,
  input wire logic ce_n,
  input wire logic rw_n,
  input wire logic oe_n,
  input wire logic [15:0] addr,
  input wire logic [7:0] wd,
  input wire logic wen,
  input wire logic r_we,
  input wire logic [2:0] r_idx,
  input wire logic r_d,
  output logic [7:0] rd
);
  logic [7:0] lreq = 8'h00;
  logic [7:0] rreq = 8'h00;
  logic [1:0] own [8] = '{default: 2'h1};
  logic hold = 1'b0;
  logic val = 1'b1;
  // One side writes one flag: 1 left, 2 right
  task automatic side_wr(input logic [1:0] s, input logic [2:0] i,
                         input logic v);
    if (s == 2'h1) lreq[i] = v;
    else rreq[i] = v;
    if (own[i] == s && v) begin
      // Pending request on the other side takes the token
      if ((s == 2'h1) ? !rreq[i] : !lreq[i]) own[i] = 2'(3 - s);
      else own[i] = 2'h0;
    end else if (own[i] == 2'h0 && !v) begin
      own[i] = s;
    end
  endtask
  // Writes, left wins a coincident request
  always @(posedge core_clk) begin
    if (!tss_n && ce_n && !rw_n && wen) begin
      side_wr(2'h1, addr[2:0], wd[0]);
    end
    if (r_we) side_wr(2'h2, r_idx, r_d);
  end
  // Read latch held while selected
  always @(posedge core_clk) begin
    if (!tss_n && !oe_n) begin
      if (!hold) val <= (own[addr[2:0]] != 2'h1);
      hold <= 1'b1;
    end else hold <= 1'b0;
  end
  // Released bus shows inverse of last value
  // No wait state: the flag value is there as soon as it is latched
  assign rd = (!tss_n && !oe_n && hold) ?
              {8{val}} : ~{8{val}};
endmodule

// File: dv/tb_dpsf_host.sv
// ========================================================
// Bench for the flag host
module tb_dpsf_host;
  timeunit 1ns;
  timeprecision 1ps;
  import dpsf_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  dpsf_cmd_t cmd = '0;
  logic cmd_ready, cmd_abort = 1'b0, rsp_valid, tss_n, ce_n, rw_n, oe_n;
  dpsf_rsp_t rsp;
  logic [15:0] addr;
  logic [7:0] data_o, data_i;
  logic data_oe, r_we = 1'b0, r_d = 1'b1;
  logic [2:0] r_idx = 3'h0;
  int bad_count = 0;
  int checks = 0;
  always #4 core_clk = ~core_clk;
  dpsf_host DUT (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .cmd_abort(cmd_abort),
    .rsp_valid(rsp_valid), .rsp(rsp), .token_space_select_n(tss_n),
    .mem_select_n(ce_n), .rw_n(rw_n), .oe_n(oe_n), .addr(addr),
    .data_o(data_o), .data_oe(data_oe), .data_i(data_i));
  dpsf_dev_model dev (.core_clk(core_clk), .tss_n(tss_n), .ce_n(ce_n),
    .rw_n(rw_n), .oe_n(oe_n), .addr(addr), .wd(data_o), .wen(data_oe),
    .r_we(r_we), .r_idx(r_idx), .r_d(r_d), .rd(data_i));
  // ======================================================
  // Shared tasks
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic ready_wait();
    int n;
    for (n = 0; n < 900 && cmd_ready !== 1'b1; n++) @(negedge core_clk);
    if (n == 900) begin
      bad_count++;
      wrap_up();
    end
  endtask
  task automatic issue(input dpsf_op_t op, input logic [2:0] i);
    ready_wait();
    cmd_valid = 1'b1;
    cmd = '{op: op, idx: i};
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask
  task automatic await(input logic g, input logic [2:0] i);
    int n;
    for (n = 0; n < 900 && rsp_valid !== 1'b1; n++) @(negedge core_clk);
    if (n == 900) begin
      bad_count++;
      wrap_up();
    end
    chk("granted", 8'(rsp.granted), 8'(g));
    chk("rsp_idx", 8'(rsp.idx), 8'(i));
  endtask
  task automatic rwr(input logic [2:0] i, input logic v);
    @(negedge core_clk);
    r_we = 1'b1;
    r_idx = i;
    r_d = v;
    @(negedge core_clk);
    r_we = 1'b0;
  endtask
  // Pin watch during token accesses
  always @(negedge core_clk) begin
    if (rst_n && !tss_n) begin
      chk("mem_sel", 8'(ce_n), 8'h01);
      chk("addr_hi", 8'(|addr[15:3]), 8'h00);
      if (!rw_n) begin
        chk("wr_data", 8'(&data_o | ~|data_o), 8'h01);
      end
    end
  end
  // ======================================================
  // Scenarios
  task automatic t_init();
    ready_wait();
    for (int i = 0; i < 8; i++) rwr(3'(i), 1'b1);
    for (int i = 0; i < 8; i++) begin
      chk("own_init", 8'(dev.own[i]), 8'h00);
    end
    $display("t_init done");
  endtask
  task automatic t_handover();
    issue(DPSF_OP_ACQ, 3'h3);
    await(1'b1, 3'h3);
    chk("own_acq", 8'(dev.own[3]), 8'h01);
    rwr(3'h3, 1'b0);
    chk("own_keep", 8'(dev.own[3]), 8'h01);
    issue(DPSF_OP_REL, 3'h3);
    await(1'b0, 3'h3);
    chk("own_pass", 8'(dev.own[3]), 8'h02);
    $display("t_handover done");
  endtask
  task automatic t_poll();
    issue(DPSF_OP_ACQ, 3'h3);
    repeat (60) @(negedge core_clk);
    chk("busy_poll", 8'(cmd_ready), 8'h00);
    rwr(3'h3, 1'b1);
    await(1'b1, 3'h3);
    chk("own_poll", 8'(dev.own[3]), 8'h01);
    issue(DPSF_OP_REL, 3'h3);
    await(1'b0, 3'h3);
    $display("t_poll done");
  endtask
  task automatic t_abort();
    rwr(3'h5, 1'b0);
    cmd_abort = 1'b1;
    issue(DPSF_OP_ACQ, 3'h5);
    await(1'b0, 3'h5);
    cmd_abort = 1'b0;
    chk("withdraw", 8'(dev.lreq[5]), 8'h01);
    rwr(3'h5, 1'b1);
    $display("t_abort done");
  endtask
  task automatic t_all();
    for (int i = 0; i < 8; i++) begin
      issue(DPSF_OP_ACQ, 3'(i));
      await(1'b1, 3'(i));
      issue(DPSF_OP_REL, 3'(i));
      await(1'b0, 3'(i));
      chk("own_rel", 8'(dev.own[i]), 8'h00);
    end
    issue(DPSF_OP_ACQ, 3'h7);
    await(1'b1, 3'h7);
    issue(DPSF_OP_POLL, 3'h0);
    ready_wait();
    issue(DPSF_OP_INIT, 3'h0);
    ready_wait();
    chk("own_ini", 8'(dev.own[7]), 8'h00);
    $display("t_all done");
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    t_init();
    t_handover();
    t_poll();
    t_abort();
    t_all();
    wrap_up();
  end
endmodule
